// ### core/scp_pkg.sv
// Shared constants for the serial command port.
package scp_pkg;
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned BAUD_RATE      = 9600;
  localparam int unsigned BIT_CYCLES_DEF = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam int unsigned DATA_BITS      = 7;
  localparam int unsigned FRAME_BITS     = 10;
  localparam int unsigned MAX_MSG        = 64;
  localparam int unsigned FIFO_DEPTH     = 16;
  localparam int unsigned WORD_W         = 9;
  localparam int unsigned CNT_W          = 14;
  localparam int unsigned LEN_W          = 7;
  localparam int unsigned PEND_W         = 4;
  localparam logic [3:0]  LAST_BIT       = 4'h9;
  localparam logic [6:0]  CH_CR          = 7'h0D;
  localparam logic [6:0]  CH_LF          = 7'h0A;
  localparam logic [6:0]  CH_SEMI        = 7'h3B;
  localparam logic [6:0]  CH_QUERY       = 7'h3F;
  localparam logic [6:0]  CH_NONE        = 7'h00;
endpackage : scp_pkg

// ### core/scp_fifo.sv
// Synchronous FIFO with a registered output stage.
`timescale 1ns/1ps
`default_nettype none
module scp_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             push;
  logic             pop;

  always_comb
  begin
    in_ready_out   = (count != (AW+1)'(DEPTH));
    push           = in_valid_in && in_ready_out;
    pop            = (count != '0) && (!out_valid_out || out_ready_in);
    next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count     = count + (AW+1)'(push) - (AW+1)'(pop);
    next_out_valid = pop || (out_valid_out && !out_ready_in);
    next_out_data  = pop ? mem[rd_ptr] : out_data_out;
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      count         <= '0;
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end
    else
    begin
      wr_ptr        <= next_wr_ptr;
      rd_ptr        <= next_rd_ptr;
      count         <= next_count;
      out_valid_out <= next_out_valid;
      out_data_out  <= next_out_data;
    end
  end
endmodule // scp_fifo
`default_nettype wire

// ### core/scp_port.sv
// Half-duplex serial command port: receives terminated messages, sends responses.
`timescale 1ns/1ps
`default_nettype none
module scp_port
  import scp_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEF
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       rxd_in,
  output logic            txd_out,
  input  wire logic       panel_busy_in,
  output logic            msg_valid_out,
  output logic [6:0]      msg_data_out,
  output logic            msg_end_out,
  output logic            msg_query_out,
  input  wire logic       msg_ready_in,
  input  wire logic       rsp_valid_in,
  input  wire logic [6:0] rsp_data_in,
  input  wire logic       rsp_last_in,
  output logic            rsp_ready_out,
  output logic            msg_drop_out,
  output logic            query_pending_out
);
  typedef enum logic {RX_IDLE, RX_RUN} scp_rx_t;
  typedef enum logic {LN_RECV, LN_DISP} scp_ln_t;
  typedef enum logic [1:0] {PH_DATA, PH_CR, PH_LF} scp_ph_t;

  localparam logic [CNT_W-1:0] BIT_END  = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_BIT = CNT_W'(BIT_CYCLES / 2);

  // Receiver.
  scp_rx_t          rx_st, next_rx_st;
  logic [CNT_W-1:0] rx_cnt, next_rx_cnt;
  logic [3:0]       rx_bit, next_rx_bit;
  logic [9:0]       rx_sh, next_rx_sh;
  logic             rx_done, next_rx_done;
  logic [6:0]       rx_char, next_rx_char;
  logic             rx_bad, next_rx_bad;
  logic             tx_active;

  always_comb
  begin
    next_rx_st   = rx_st;
    next_rx_cnt  = rx_cnt;
    next_rx_bit  = rx_bit;
    next_rx_sh   = rx_sh;
    next_rx_done = 1'b0;
    next_rx_char = rx_char;
    next_rx_bad  = rx_bad;
    case (rx_st)
      RX_IDLE:
      begin
        if (!rxd_in && !tx_active)
        begin
          next_rx_st  = RX_RUN;
          next_rx_cnt = HALF_BIT;
          next_rx_bit = 4'h0;
        end
      end
      RX_RUN:
      begin
        if (rx_cnt != '0)
        begin
          next_rx_cnt = rx_cnt - 1'b1;
        end
        else
        begin
          next_rx_cnt = BIT_END;
          next_rx_sh  = {rxd_in, rx_sh[9:1]};
          next_rx_bit = rx_bit + 1'b1;
          if (rx_bit == 4'h0 && rxd_in)
          begin
            next_rx_st = RX_IDLE;
          end
          else if (rx_bit == LAST_BIT)
          begin
            next_rx_st   = RX_IDLE;
            next_rx_done = 1'b1;
            next_rx_char = next_rx_sh[7:1];
            next_rx_bad  = !(^next_rx_sh[8:1]) || !next_rx_sh[9];
          end
        end
      end
      default: next_rx_st = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_st   <= RX_IDLE;
      rx_cnt  <= '0;
      rx_bit  <= '0;
      rx_sh   <= '0;
      rx_done <= 1'b0;
      rx_char <= '0;
      rx_bad  <= 1'b0;
    end
    else
    begin
      rx_st   <= next_rx_st;
      rx_cnt  <= next_rx_cnt;
      rx_bit  <= next_rx_bit;
      rx_sh   <= next_rx_sh;
      rx_done <= next_rx_done;
      rx_char <= next_rx_char;
      rx_bad  <= next_rx_bad;
    end
  end

  // Line buffer and splitter. The whole message is held until its terminator
  // so that a late error can still discard it; this costs 64 words of storage.
  logic [6:0]        line_mem [MAX_MSG];
  scp_ln_t           ln_st, next_ln_st;
  logic [LEN_W-1:0]  line_len, next_line_len;
  logic [LEN_W-1:0]  rd_idx, next_rd_idx;
  logic              line_err, next_line_err;
  logic              prev_cr, next_prev_cr;
  logic              str_any, next_str_any;
  logic              str_q, next_str_q;
  logic              next_drop;
  logic [PEND_W-1:0] pend, next_pend;
  logic              mem_we;
  logic              f_valid, f_ready;
  logic [WORD_W-1:0] f_data;
  logic              lf_load;
  logic [6:0]        ch;

  always_comb
  begin
    next_ln_st    = ln_st;
    next_line_len = line_len;
    next_rd_idx   = rd_idx;
    next_line_err = line_err;
    next_prev_cr  = prev_cr;
    next_str_any  = str_any;
    next_str_q    = str_q;
    next_drop     = 1'b0;
    mem_we        = 1'b0;
    f_valid       = 1'b0;
    f_data        = '0;
    ch            = line_mem[rd_idx[5:0]];
    case (ln_st)
      LN_RECV:
      begin
        if (rx_done)
        begin
          if (rx_char == CH_LF && prev_cr)
          begin
            if (!line_err && !rx_bad && !panel_busy_in)
            begin
              next_ln_st   = LN_DISP;
              next_rd_idx  = '0;
              next_str_any = 1'b0;
              next_str_q   = 1'b0;
              // The length is kept so that the splitter knows where the stored message ends.
            end
            else
            begin
              next_drop     = 1'b1;
              next_line_len = '0;
            end
            next_line_err = 1'b0;
            next_prev_cr  = 1'b0;
          end
          else
          begin
            if (line_len >= LEN_W'(MAX_MSG - 1))
            begin
              next_line_err = 1'b1;
            end
            else
            begin
              mem_we        = 1'b1;
              next_line_len = line_len + 1'b1;
            end
            next_line_err = next_line_err || rx_bad || panel_busy_in;
            next_prev_cr  = (rx_char == CH_CR);
          end
        end
      end
      LN_DISP:
      begin
        // The stored carriage return is the last word and closes the string.
        if (!panel_busy_in)
        begin
          if (ch == CH_SEMI || ch == CH_CR)
          begin
            f_valid = str_any;
            f_data  = {1'b1, str_q, CH_NONE};
            if (f_ready || !str_any)
            begin
              next_str_any = 1'b0;
              next_str_q   = 1'b0;
              next_rd_idx  = rd_idx + 1'b1;
              if (ch == CH_CR && rd_idx + 1'b1 == line_len)
              begin
                next_ln_st    = LN_RECV;
                next_line_len = '0;
              end
            end
          end
          else
          begin
            f_valid = 1'b1;
            f_data  = {1'b0, 1'b0, ch};
            if (f_ready)
            begin
              next_str_any = 1'b1;
              next_str_q   = str_q || (ch == CH_QUERY);
              next_rd_idx  = rd_idx + 1'b1;
            end
          end
        end
      end
      default: next_ln_st = LN_RECV;
    endcase
    next_pend = pend + PEND_W'(f_valid && f_ready && f_data[8] && f_data[7])
                     - PEND_W'(lf_load);
  end

  always_ff @(posedge clk_in)
  begin
    if (mem_we)
    begin
      line_mem[line_len[5:0]] <= rx_char;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ln_st             <= LN_RECV;
      line_len          <= '0;
      rd_idx            <= '0;
      line_err          <= 1'b0;
      prev_cr           <= 1'b0;
      str_any           <= 1'b0;
      str_q             <= 1'b0;
      msg_drop_out      <= 1'b0;
      pend              <= '0;
      query_pending_out <= 1'b0;
    end
    else
    begin
      ln_st             <= next_ln_st;
      line_len          <= next_line_len;
      rd_idx            <= next_rd_idx;
      line_err          <= next_line_err;
      prev_cr           <= next_prev_cr;
      str_any           <= next_str_any;
      str_q             <= next_str_q;
      msg_drop_out      <= next_drop;
      pend              <= next_pend;
      query_pending_out <= (next_pend != '0);
    end
  end

  scp_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (f_valid),
    .in_data_in    (f_data),
    .in_ready_out  (f_ready),
    .out_valid_out (msg_valid_out),
    .out_data_out  ({msg_end_out, msg_query_out, msg_data_out}),
    .out_ready_in  (msg_ready_in)
  );

  // Transmitter: response characters, then the terminator pair.
  scp_ph_t          ph, next_ph;
  logic [9:0]       tx_sh, next_tx_sh;
  logic [CNT_W-1:0] tx_cnt, next_tx_cnt;
  logic [3:0]       tx_bit, next_tx_bit;
  logic             next_tx_active;
  logic             next_ack;
  logic [6:0]       ld_char;
  logic             ld;

  always_comb
  begin
    next_ph        = ph;
    next_tx_sh     = tx_sh;
    next_tx_cnt    = tx_cnt;
    next_tx_bit    = tx_bit;
    next_tx_active = tx_active;
    next_ack       = 1'b0;
    lf_load        = 1'b0;
    ld             = 1'b0;
    ld_char        = CH_NONE;
    if (!tx_active)
    begin
      // A start bit already on the line wins, so the two directions never overlap.
      if (pend != '0 && rx_st == RX_IDLE && rxd_in && !panel_busy_in)
      begin
        case (ph)
          PH_DATA:
          begin
            ld       = rsp_valid_in;
            ld_char  = rsp_data_in;
            next_ack = rsp_valid_in;
            if (rsp_valid_in && rsp_last_in)
            begin
              next_ph = PH_CR;
            end
          end
          PH_CR:
          begin
            ld      = 1'b1;
            ld_char = CH_CR;
            next_ph = PH_LF;
          end
          PH_LF:
          begin
            ld      = 1'b1;
            ld_char = CH_LF;
            lf_load = 1'b1;
            next_ph = PH_DATA;
          end
          default: next_ph = PH_DATA;
        endcase
      end
      if (ld)
      begin
        next_tx_sh     = {1'b1, ~^ld_char, ld_char, 1'b0};
        next_tx_cnt    = '0;
        next_tx_bit    = 4'h0;
        next_tx_active = 1'b1;
      end
    end
    else if (tx_cnt == BIT_END)
    begin
      next_tx_cnt = '0;
      next_tx_sh  = {1'b1, tx_sh[9:1]};
      next_tx_bit = tx_bit + 1'b1;
      if (tx_bit == LAST_BIT)
      begin
        next_tx_active = 1'b0;
      end
    end
    else
    begin
      next_tx_cnt = tx_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ph            <= PH_DATA;
      tx_sh         <= '1;
      tx_cnt        <= '0;
      tx_bit        <= '0;
      tx_active     <= 1'b0;
      rsp_ready_out <= 1'b0;
      txd_out       <= 1'b1;
    end
    else
    begin
      ph            <= next_ph;
      tx_sh         <= next_tx_sh;
      tx_cnt        <= next_tx_cnt;
      tx_bit        <= next_tx_bit;
      tx_active     <= next_tx_active;
      rsp_ready_out <= next_ack;
      txd_out       <= !next_tx_active || next_tx_sh[0];
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_half_duplex: assert property (!(tx_active && rx_st == RX_RUN))
    else $error("Receive and transmit active together.");
  a_start_bit_low: assert property (tx_active && tx_bit == 4'h0 |-> !txd_out)
    else $error("Start bit is not low.");
  a_stop_bit_high: assert property (tx_active && tx_bit == LAST_BIT |-> txd_out)
    else $error("Stop bit is not high.");
  a_parity_odd: assert property ($rose(tx_active) |-> ^tx_sh[8:1])
    else $error("Transmitted parity is not odd.");
  a_bit_period: assert property (tx_active && $past(tx_active) && tx_bit != $past(tx_bit)
                                 |-> $past(tx_cnt) == BIT_END)
    else $error("Bit period length is wrong.");
  a_tx_needs_query: assert property ($rose(tx_active) |-> $past(pend) != '0)
    else $error("Transmission started without a pending query.");
  a_panel_quiet: assert property (panel_busy_in && !tx_active |=> !tx_active)
    else $error("Transmission started during panel setup.");
  a_error_drop: assert property (rx_done && rx_bad && rx_char == CH_LF && prev_cr
                                 && ln_st == LN_RECV |=> msg_drop_out && ln_st == LN_RECV)
    else $error("Bad message was not discarded.");
  a_lf_ends_rsp: assert property (lf_load |=> tx_sh[7:1] == CH_LF && ph == PH_DATA)
    else $error("Response did not end with line feed.");
  a_no_semi_out: assert property (f_valid |-> f_data[6:0] != CH_SEMI)
    else $error("Separator leaked into the string stream.");

  c_query_answered: cover property (lf_load);
  c_msg_dropped: cover property (msg_drop_out);
  c_query_word: cover property (msg_valid_out && msg_end_out && msg_query_out && msg_ready_in);
  c_fifo_full: cover property (f_valid && !f_ready);
endmodule // scp_port
`default_nettype wire

// ### tb/scp_host_model.sv
// Host computer model: sends framed characters to the port and decodes its replies.
`timescale 1ns/1ps
`default_nettype none
module scp_host_model #(
  parameter int unsigned BIT_CYCLES = 16
) (
  input  wire logic clk_in,
  output logic      rxd_out,
  input  wire logic txd_in
);
  logic [8:0] rx_q[$];
  logic [9:0] tsh;
  logic [8:0] rsh;

  // The line rests at the mark level between frames; there are no handshake lines.
  initial rxd_out = 1'b1;

  // A corrupted parity bit is sent only when a scenario asks for it.
  task automatic send_char(input logic [6:0] c, input logic bad);
    tsh = {1'b1, (~^c) ^ bad, c, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd_out = tsh[i];
      repeat (BIT_CYCLES) @(posedge clk_in);
      #1;
    end
  endtask

  // Each entry holds parity good, stop good and the seven data bits.
  always
  begin
    @(negedge txd_in);
    repeat (BIT_CYCLES / 2) @(posedge clk_in);
    if (txd_in === 1'b0)
    begin
      for (int i = 0; i < 9; i++)
      begin
        repeat (BIT_CYCLES) @(posedge clk_in);
        rsh[i] = txd_in;
      end
      rx_q.push_back({(^rsh[7:0]) === 1'b1, rsh[8] === 1'b1, rsh[6:0]});
    end
  end
endmodule // scp_host_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking testbench for the serial command port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import scp_pkg::*;
  localparam int unsigned BITC = 16;
  logic       clk_in;
  logic       rst_n_in;
  logic       rxd;
  logic       txd;
  logic       panel_busy;
  logic       msg_valid;
  logic [6:0] msg_data;
  logic       msg_end;
  logic       msg_query;
  logic       msg_ready;
  logic       rsp_valid;
  logic [6:0] rsp_data;
  logic       rsp_last;
  logic       rsp_ready;
  logic       msg_drop;
  logic       query_pending;
  logic [8:0] got[$];
  logic [8:0] exp[$];
  int         fail_count;
  int         n_compared;
  int         drops;

  scp_port #(.BIT_CYCLES(BITC)) uut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .rxd_in(rxd), .txd_out(txd),
    .panel_busy_in(panel_busy), .msg_valid_out(msg_valid), .msg_data_out(msg_data),
    .msg_end_out(msg_end), .msg_query_out(msg_query), .msg_ready_in(msg_ready),
    .rsp_valid_in(rsp_valid), .rsp_data_in(rsp_data), .rsp_last_in(rsp_last),
    .rsp_ready_out(rsp_ready), .msg_drop_out(msg_drop), .query_pending_out(query_pending)
  );

  scp_host_model #(.BIT_CYCLES(BITC)) host (.clk_in(clk_in), .rxd_out(rxd), .txd_in(txd));

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
  begin
    if (msg_valid === 1'b1 && msg_ready === 1'b1)
      got.push_back({msg_end, msg_query, msg_data});
    if (msg_drop === 1'b1)
      drops++;
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [8:0] a, input logic [8:0] e);
    n_compared++;
    if (a !== e)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic wait_for(input int n, input logic rx);
    int k;
    k = 0;
    while (((rx ? host.rx_q.size() : got.size()) < n) && k < 3000)
    begin
      step(1);
      k++;
    end
    if (k >= 3000)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, k, n);
      results();
    end
  endtask

  task automatic send_rep(input int n, input int bad_at);
    for (int i = 0; i < n; i++)
      host.send_char(7'h41, i == bad_at);
    host.send_char(CH_CR, 1'b0);
    host.send_char(CH_LF, 1'b0);
  endtask

  task automatic send_msg(input string s, input int bad_at);
    byte b;
    for (int i = 0; i < s.len(); i++)
    begin
      b = s[i];
      host.send_char(b[6:0], i == bad_at);
    end
    host.send_char(CH_CR, bad_at == s.len());
    host.send_char(CH_LF, bad_at == s.len() + 1);
  endtask

  task automatic expect_str(input string s, input logic q);
    byte b;
    for (int i = 0; i < s.len(); i++)
    begin
      b = s[i];
      exp.push_back({2'b00, b[6:0]});
    end
    exp.push_back({1'b1, q, CH_NONE});
  endtask

  task automatic flush_words(input int n);
    wait_for(n, 1'b0);
    step(10);
    check(9'(got.size()), 9'(exp.size()));
    for (int i = 0; i < got.size() && i < exp.size(); i++)
      check(got[i], exp[i]);
    got.delete();
    exp.delete();
  endtask

  task automatic rsp_char(input logic [6:0] c, input logic last);
    int k;
    k = 0;
    rsp_valid = 1'b1;
    rsp_data = c;
    rsp_last = last;
    do
    begin
      step(1);
      k++;
    end while (rsp_ready !== 1'b1 && k < 400);
    check(9'(k < 400), 9'h001);
    if (k >= 400)
      results();
  endtask

  // The drop pulse comes while the last stop bit is still on the line, so callers take
  // the count before sending.
  task automatic expect_drop(input int d0);
    step(20);
    check(9'(drops - d0), 9'h001);
    check(9'(got.size()), 9'h000);
    check({8'h00, query_pending}, 9'h000);
  endtask

  task automatic t_command_fill();
    msg_ready = 1'b0;
    send_msg("ABCDEFGHIJKLMNOPQ 5", -1);
    step(300);
    check(9'(got.size()), 9'h000);
    msg_ready = 1'b1;
    expect_str("ABCDEFGHIJKLMNOPQ 5", 1'b0);
    flush_words(20);
    check({8'h00, query_pending}, 9'h000);
    check(9'(host.rx_q.size()), 9'h000);
    $display("test command_fill done");
  endtask

  task automatic t_chain_query();
    logic [6:0] e[4];
    e = '{7'h34, 7'h32, CH_CR, CH_LF};
    send_msg("X?;Y 1", -1);
    expect_str("X?", 1'b1);
    expect_str("Y 1", 1'b0);
    flush_words(7);
    check({8'h00, query_pending}, 9'h001);
    rsp_char(7'h34, 1'b0);
    rsp_char(7'h32, 1'b1);
    rsp_valid = 1'b0;
    wait_for(4, 1'b1);
    step(4 * BITC);
    for (int i = 0; i < 4; i++)
      check(host.rx_q[i], {2'b11, e[i]});
    check(9'(host.rx_q.size()), 9'h004);
    check({8'h00, query_pending}, 9'h000);
    host.rx_q.delete();
    $display("test chain_query done");
  endtask

  task automatic t_unprompted();
    int k;
    k = 0;
    rsp_valid = 1'b1;
    rsp_data = 7'h55;
    rsp_last = 1'b1;
    for (int i = 0; i < 300; i++)
    begin
      step(1);
      if (rsp_ready !== 1'b0)
        k++;
    end
    rsp_valid = 1'b0;
    check(9'(k), 9'h000);
    check(9'(host.rx_q.size()), 9'h000);
    $display("test unprompted done");
  endtask

  task automatic t_drops();
    int d;
    d = drops;
    send_msg("Z?", 0);
    expect_drop(d);
    d = drops;
    send_msg("Q?", 3);
    expect_drop(d);
    d = drops;
    panel_busy = 1'b1;
    send_msg("P?", -1);
    step(5);
    panel_busy = 1'b0;
    expect_drop(d);
    $display("test drops done");
  endtask

  task automatic t_length();
    int d;
    send_rep(62, -1);
    for (int i = 0; i < 62; i++)
      exp.push_back({2'b00, 7'h41});
    exp.push_back({1'b1, 1'b0, CH_NONE});
    flush_words(63);
    d = drops;
    send_rep(63, -1);
    expect_drop(d);
    d = drops;
    send_rep(2, 1);
    expect_drop(d);
    $display("test length done");
  endtask

  initial
  begin
    rst_n_in = 1'b0;
    panel_busy = 1'b0;
    msg_ready = 1'b1;
    rsp_valid = 1'b0;
    rsp_data = 7'h00;
    rsp_last = 1'b0;
    fail_count = 0;
    n_compared = 0;
    drops = 0;
    step(2);
    rst_n_in = 1'b1;
    step(2);
    t_command_fill();
    step(8 * BITC);
    t_chain_query();
    step(8 * BITC);
    t_unprompted();
    t_drops();
    step(8 * BITC);
    t_length();
    results();
  end
endmodule // tb_top
`default_nettype wire
